// [dcss_defs.vh]
// Offsets, field positions, encodings and timing for the command source selector
`ifndef DCSS_DEFS_VH
`define DCSS_DEFS_VH
// Register byte offsets
`define DCSS_CFG_OFS        8'h00
`define DCSS_MODE_OFS       8'h04
`define DCSS_LINK_OFS       8'h08
`define DCSS_CTRL_OFS       8'h0C
`define DCSS_FREQ_OFS       8'h10
`define DCSS_PARAM_OFS      8'h14
`define DCSS_MONSEL_OFS     8'h18
`define DCSS_STAT_OFS       8'h1C
`define DCSS_MFREQ_OFS      8'h20
`define DCSS_MCURR_OFS      8'h24
`define DCSS_MVOLT_OFS      8'h28
`define DCSS_MSPEC_OFS      8'h2C
// Configuration fields
`define DCSS_CFG_RUNSRC     0
`define DCSS_CFG_SPDSRC     1
`define DCSS_CFG_REM_LO     2
`define DCSS_CFG_OPSEL_LO   4
`define DCSS_CFG_LSTART     8
`define DCSS_CFG_WINH_LO    9
`define DCSS_CFG_RESET      11'h000
// Operation modes
`define DCSS_MODE_PU        2'h0
`define DCSS_MODE_EXT       2'h1
`define DCSS_MODE_NET       2'h2
`define DCSS_MODE_RESET     2'h1
// Link command bits
`define DCSS_LK_FWD         0
`define DCSS_LK_REV         1
`define DCSS_LK_HIGH        2
`define DCSS_LK_MID         3
`define DCSS_LK_LOW         4
`define DCSS_LK_EXT15       5
`define DCSS_LK_SECOND      6
`define DCSS_LK_CURIN       7
`define DCSS_LK_SELFHOLD    8
`define DCSS_LK_SHUTOFF     9
`define DCSS_LK_FLUX        10
`define DCSS_LK_W           11
// Control pulse bits
`define DCSS_CT_INVRST      0
`define DCSS_CT_FLTRST      1
`define DCSS_CT_FRAM        2
`define DCSS_CT_FNV         3
`define DCSS_CT_PWR         4
// Status bits
`define DCSS_ST_COMMERR     8
`define DCSS_ST_PWERR       9
`define DCSS_ST_RSTREJ      10
// Encodings
`define DCSS_OPSEL_INTERLOCK 4'h7
`define DCSS_SPECIAL_CODE   8'hF3
`define DCSS_MONSEL_RESET   8'h00
// Refresh watchdog: longest refresh period in us and clock rate in MHz
`define DCSS_REFRESH_MAX_US 141000
`define DCSS_CLK_MHZ        40
`endif

// [dcss_top.v]
// Drive command source selection with AHB-Lite register access
`timescale 1ns/100ps
`include "dcss_defs.vh"

module dcss_sync3 #(
    parameter W = 1
) (
    input  wire         hclk,
    input  wire         hresetn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Accept a change only once two stages agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // dcss_sync3

// What this block does
// - Run commands from network or terminals
// - Speed steps follow speed source setting
// - Remote setting inputs follow speed source
// - Second function follows run source
// - Flux/VF switch follows run source
// - Current input both when speed external
// - Self-holding from terminals when run external
// - Thermal relay always from terminals
// - Interlock mode: shutoff from terminal only
// - Exclusive sources ignore the other
// - Cyclic refresh within 141 ms
// - Network reset rejected on comm error
// - Fault reset accepted in every mode
// - Hardware reset terminal always honoured
// - Network mode gates terminals by settings
// - Network reset returns to external mode, or to network mode if link start is set
// - Monitor values unsigned binary scaled
// - Special monitor returns selected item
// - Status bits readable any time
// - Frequency written to RAM or nonvolatile
// - Parameter write while running errors, except exempt numbers
// - Both link directions means stop
module dcss_top #(
    parameter REFRESH_MAX_CYC = `DCSS_REFRESH_MAX_US * `DCSS_CLK_MHZ
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        term_fwd,
    input  wire        term_rev,
    input  wire        term_low,
    input  wire        term_mid,
    input  wire        term_high,
    input  wire        term_ext15,
    input  wire        term_second,
    input  wire        term_curin,
    input  wire        term_selfhold,
    input  wire        term_shutoff,
    input  wire        term_thermal,
    input  wire        term_pu_ext,
    input  wire        term_flux,
    input  wire        hw_reset_in,
    input  wire        inv_fwd_running,
    input  wire        inv_rev_running,
    input  wire        inv_running,
    input  wire        up_to_freq_flag,
    input  wire        overload_flag,
    input  wire        freq_detect_flag,
    input  wire        inv_alarm,
    input  wire [15:0] mon_freq,
    input  wire [15:0] mon_curr,
    input  wire [15:0] mon_volt,
    input  wire [15:0] mon_special,
    output reg         fwd_run_cmd,
    output reg         rev_run_cmd,
    output reg         speed_sel_low,
    output reg         speed_sel_mid,
    output reg         speed_sel_high,
    output reg         speed_sel_ext15,
    output reg         remote_setting_active,
    output reg         second_func_sel,
    output reg         current_input_sel,
    output reg         start_self_hold,
    output reg         output_shutoff,
    output reg         thermal_relay_in,
    output reg         pu_ext_switch,
    output reg         flux_vf_switch,
    output reg         inv_reset_out,
    output reg         fault_error_reset_req,
    output reg         freq_ram_we,
    output reg         freq_nv_we,
    output reg  [15:0] set_freq,
    output reg         param_we,
    output reg  [9:0]  param_num,
    output reg  [15:0] param_data,
    output reg  [7:0]  special_mon_sel,
    output reg  [1:0]  op_mode
);
    // Synchronised terminals
    wire [13:0] term_s;
    dcss_sync3 #(.W(14)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({hw_reset_in, term_flux, term_pu_ext, term_thermal, term_shutoff,
                   term_selfhold, term_curin, term_second, term_ext15, term_high,
                   term_mid, term_low, term_rev, term_fwd}),
        .dout    (term_s)
    );

    reg  [10:0] cfg_q;
    reg  [10:0] link_q;
    reg  [15:0] freq_q;
    reg  [9:0]  pnum_q;
    reg  [15:0] pdata_q;
    reg  [7:0]  monsel_q;
    reg         commerr_q;
    reg         pwerr_q;
    reg         rstrej_q;
    reg  [22:0] wd_q;
    reg         wr_pend_q;
    reg  [7:0]  wr_addr_q;

    wire        run_ext  = cfg_q[`DCSS_CFG_RUNSRC];
    wire        spd_ext  = cfg_q[`DCSS_CFG_SPDSRC];
    wire [1:0]  remote   = cfg_q[`DCSS_CFG_REM_LO +: 2];
    wire [3:0]  opsel    = cfg_q[`DCSS_CFG_OPSEL_LO +: 4];
    wire        lstart   = cfg_q[`DCSS_CFG_LSTART];
    wire        net_mode = (op_mode == `DCSS_MODE_NET);
    wire        ext_mode = (op_mode == `DCSS_MODE_EXT);

    // AHB-Lite: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    wire   acc    = hsel & hready & htrans[1];
    wire   wr_now = wr_pend_q;
    wire   wr_cfg  = wr_now && (wr_addr_q == `DCSS_CFG_OFS);
    wire   wr_mode = wr_now && (wr_addr_q == `DCSS_MODE_OFS);
    wire   wr_link = wr_now && (wr_addr_q == `DCSS_LINK_OFS);
    wire   wr_ctrl = wr_now && (wr_addr_q == `DCSS_CTRL_OFS);
    wire   wr_stat = wr_now && (wr_addr_q == `DCSS_STAT_OFS);

    // Parameters that may change while running
    function pw_exempt;
        input [9:0] n;
        begin
            pw_exempt = (n >= 10'd4 && n <= 10'd6) || (n == 10'd22) ||
                        (n >= 10'd24 && n <= 10'd27) || (n >= 10'd52 && n <= 10'd56) ||
                        (n == 10'd72) || (n >= 10'd232 && n <= 10'd239);
        end
    endfunction

    // Control requests decoded from the written word
    wire req_invrst = wr_ctrl & hwdata[`DCSS_CT_INVRST];
    wire req_fltrst = wr_ctrl & hwdata[`DCSS_CT_FLTRST];
    wire req_fram   = wr_ctrl & hwdata[`DCSS_CT_FRAM];
    wire req_fnv    = wr_ctrl & hwdata[`DCSS_CT_FNV];
    wire req_pwr    = wr_ctrl & hwdata[`DCSS_CT_PWR];
    wire rst_ok     = net_mode & ~commerr_q;
    wire pw_ok      = net_mode & (~inv_running | pw_exempt(pnum_q));

    // Register writes and side effects
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            cfg_q     <= `DCSS_CFG_RESET;
            link_q    <= {`DCSS_LK_W{1'b0}};
            freq_q    <= 16'h0000;
            pnum_q    <= 10'h000;
            pdata_q   <= 16'h0000;
            monsel_q  <= `DCSS_MONSEL_RESET;
            op_mode   <= `DCSS_MODE_RESET;
            commerr_q <= 1'b0;
            pwerr_q   <= 1'b0;
            rstrej_q  <= 1'b0;
            wd_q      <= 23'h00_0000;
            inv_reset_out         <= 1'b0;
            fault_error_reset_req <= 1'b0;
            freq_ram_we <= 1'b0;
            freq_nv_we  <= 1'b0;
            param_we    <= 1'b0;
        end else begin
            wr_pend_q <= acc & hwrite;
            if (acc) begin
                wr_addr_q <= {haddr[7:2], 2'b00};
            end
            if (wr_cfg) begin
                cfg_q <= hwdata[10:0];
            end
            if (wr_mode && hwdata[1:0] != 2'h3) begin
                op_mode <= hwdata[1:0];
            end
            if (wr_now && wr_addr_q == `DCSS_FREQ_OFS) begin
                freq_q <= hwdata[15:0];
            end
            if (wr_now && wr_addr_q == `DCSS_PARAM_OFS) begin
                pnum_q  <= hwdata[9:0];
                pdata_q <= hwdata[31:16];
            end
            if (wr_now && wr_addr_q == `DCSS_MONSEL_OFS) begin
                monsel_q <= hwdata[7:0];
            end
            // Each link command write is one refresh; silence past the limit is an error
            if (wr_link) begin
                link_q <= hwdata[`DCSS_LK_W-1:0];
                wd_q   <= 23'h00_0000;
            end else if (wd_q < REFRESH_MAX_CYC[22:0]) begin
                wd_q <= wd_q + 23'h00_0001;
            end
            if (!wr_link && wd_q >= REFRESH_MAX_CYC[22:0] - 23'h00_0001) begin
                commerr_q <= 1'b1;
            end else if (wr_link) begin
                commerr_q <= 1'b0;
            end
            // Network reset: only in network mode and without comm error
            inv_reset_out <= term_s[13] | (req_invrst & rst_ok);
            if (req_invrst & rst_ok) begin
                op_mode <= lstart ? `DCSS_MODE_NET : `DCSS_MODE_EXT;
            end
            fault_error_reset_req <= req_fltrst;
            // Frequency may only be set from the network in network mode
            freq_ram_we <= req_fram & net_mode;
            freq_nv_we  <= req_fnv & net_mode;
            param_we    <= req_pwr & pw_ok;
            // Sticky flags: a new event wins over a clear in the same cycle
            if (req_invrst & ~rst_ok) begin
                rstrej_q <= 1'b1;
            end else if (wr_stat & hwdata[`DCSS_ST_RSTREJ]) begin
                rstrej_q <= 1'b0;
            end
            if (req_pwr & ~pw_ok) begin
                pwerr_q <= 1'b1;
            end else if (wr_stat & hwdata[`DCSS_ST_PWERR]) begin
                pwerr_q <= 1'b0;
            end
        end
    end

    // Source selection; link bits count only in network mode
    reg lk_fwd;
    reg lk_rev;
    reg use_net;
    reg [13:0] drv_d;
    always @* begin
        use_net = net_mode;
        lk_fwd  = link_q[`DCSS_LK_FWD] & ~link_q[`DCSS_LK_REV];
        lk_rev  = link_q[`DCSS_LK_REV] & ~link_q[`DCSS_LK_FWD];
        drv_d   = 14'h0000;
        if (use_net) begin
            // Each input except current input and shutoff takes only its selected source; the other is dropped
            drv_d[0] = run_ext ? term_s[0] : lk_fwd;
            drv_d[1] = run_ext ? term_s[1] : lk_rev;
            drv_d[2] = spd_ext ? term_s[2] : link_q[`DCSS_LK_LOW];
            drv_d[3] = spd_ext ? term_s[3] : link_q[`DCSS_LK_MID];
            drv_d[4] = spd_ext ? term_s[4] : link_q[`DCSS_LK_HIGH];
            drv_d[5] = (remote == 2'h0) &
                       (spd_ext ? term_s[5] : link_q[`DCSS_LK_EXT15]);
            drv_d[6] = run_ext ? term_s[6] : link_q[`DCSS_LK_SECOND];
            drv_d[7] = spd_ext & (term_s[7] | link_q[`DCSS_LK_CURIN]);
            drv_d[8] = run_ext & term_s[8];
            if (opsel == `DCSS_OPSEL_INTERLOCK || run_ext) begin
                drv_d[9] = term_s[9];
            end else begin
                drv_d[9] = term_s[9] | link_q[`DCSS_LK_SHUTOFF];
            end
            drv_d[11] = term_s[11];
            drv_d[12] = run_ext ? term_s[12] : link_q[`DCSS_LK_FLUX];
        end else if (ext_mode) begin
            drv_d[12:0] = term_s[12:0];
            drv_d[5]    = (remote == 2'h0) & term_s[5];
        end else begin
            // Panel mode: terminals hold no run or speed authority
            drv_d[9]  = term_s[9];
            drv_d[11] = term_s[11];
        end
        drv_d[10] = term_s[10];
        drv_d[13] = (remote != 2'h0);
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fwd_run_cmd           <= 1'b0;
            rev_run_cmd           <= 1'b0;
            speed_sel_low         <= 1'b0;
            speed_sel_mid         <= 1'b0;
            speed_sel_high        <= 1'b0;
            speed_sel_ext15       <= 1'b0;
            second_func_sel       <= 1'b0;
            current_input_sel     <= 1'b0;
            start_self_hold       <= 1'b0;
            output_shutoff        <= 1'b0;
            thermal_relay_in      <= 1'b0;
            pu_ext_switch         <= 1'b0;
            flux_vf_switch        <= 1'b0;
            remote_setting_active <= 1'b0;
            set_freq              <= 16'h0000;
            param_num             <= 10'h000;
            param_data            <= 16'h0000;
            special_mon_sel       <= `DCSS_MONSEL_RESET;
        end else begin
            fwd_run_cmd           <= drv_d[0];
            rev_run_cmd           <= drv_d[1];
            speed_sel_low         <= drv_d[2];
            speed_sel_mid         <= drv_d[3];
            speed_sel_high        <= drv_d[4];
            speed_sel_ext15       <= drv_d[5];
            second_func_sel       <= drv_d[6];
            current_input_sel     <= drv_d[7];
            start_self_hold       <= drv_d[8];
            output_shutoff        <= drv_d[9];
            thermal_relay_in      <= drv_d[10];
            pu_ext_switch         <= drv_d[11];
            flux_vf_switch        <= drv_d[12];
            remote_setting_active <= drv_d[13];
            set_freq              <= freq_q;
            param_num             <= pnum_q;
            param_data            <= pdata_q;
            special_mon_sel       <= monsel_q;
        end
    end

    // Read data registered in the address phase, so zero wait states
    wire [15:0] inv_status = {9'h000, inv_alarm, freq_detect_flag, overload_flag,
                              up_to_freq_flag, inv_running, inv_rev_running,
                              inv_fwd_running};
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            case ({haddr[7:2], 2'b00})
                `DCSS_CFG_OFS:    hrdata <= {21'h00_0000, cfg_q};
                `DCSS_MODE_OFS:   hrdata <= {30'h0000_0000, op_mode};
                `DCSS_LINK_OFS:   hrdata <= {21'h00_0000, link_q};
                `DCSS_FREQ_OFS:   hrdata <= {16'h0000, freq_q};
                `DCSS_PARAM_OFS:  hrdata <= {pdata_q, 6'h00, pnum_q};
                `DCSS_MONSEL_OFS: hrdata <= {24'h00_0000, monsel_q};
                `DCSS_STAT_OFS:   hrdata <= {21'h00_0000, rstrej_q, pwerr_q, commerr_q,
                                             inv_status[7:0]};
                `DCSS_MFREQ_OFS:  hrdata <= {16'h0000, mon_freq};
                `DCSS_MCURR_OFS:  hrdata <= {16'h0000, mon_curr};
                `DCSS_MVOLT_OFS:  hrdata <= {16'h0000, mon_volt};
                `DCSS_MSPEC_OFS:  hrdata <= (monsel_q == `DCSS_SPECIAL_CODE) ?
                                            {16'h0000, mon_special} : 32'h0000_0000;
                default:          hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // dcss_top

// [dcss_asserts.sv]
// Port-level assertions for the command source selector
`timescale 1ns/100ps
module dcss_asserts (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    input wire        term_thermal,
    input wire        hw_reset_in,
    input wire        inv_fwd_running,
    input wire        inv_rev_running,
    input wire        inv_running,
    input wire        up_to_freq_flag,
    input wire        overload_flag,
    input wire        freq_detect_flag,
    input wire        inv_alarm,
    input wire [15:0] mon_freq,
    input wire        fwd_run_cmd,
    input wire        rev_run_cmd,
    input wire        thermal_relay_in,
    input wire        inv_reset_out,
    input wire        fault_error_reset_req,
    input wire        freq_ram_we,
    input wire        freq_nv_we,
    input wire        param_we,
    input wire [9:0]  param_num,
    input wire [1:0]  op_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd_go = hsel && hready && htrans[1] && !hwrite;
    function automatic bit run_ok(input logic [9:0] n);
        run_ok = (n >= 4 && n <= 6) || n == 22 || (n >= 24 && n <= 27)
            || (n >= 52 && n <= 56) || n == 72 || (n >= 232 && n <= 239);
    endfunction
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_pu_stop: assert property ((op_mode == 2'h0) [*3] |-> !fwd_run_cmd && !rev_run_cmd)
        else $error("run command in panel mode");
    a_fault_pulse: assert property (fault_error_reset_req |=> !fault_error_reset_req)
        else $error("fault reset longer than one cycle");
    a_freq_net: assert property (freq_ram_we || freq_nv_we |-> op_mode == 2'h2)
        else $error("frequency write outside network mode");
    a_param_run: assert property (param_we && inv_running |-> run_ok(param_num))
        else $error("parameter write while running");
    a_thermal_on: assert property (term_thermal [*8] |-> thermal_relay_in)
        else $error("thermal input not followed");
    a_thermal_off: assert property (!term_thermal [*8] |-> !thermal_relay_in)
        else $error("thermal input stuck");
    a_hw_reset: assert property (hw_reset_in [*8] |-> inv_reset_out)
        else $error("reset terminal ignored");
    a_stat_read: assert property (rd_go && haddr == 8'h1C |=> hrdata[6:0] == $past({inv_alarm,
        freq_detect_flag, overload_flag, up_to_freq_flag, inv_running, inv_rev_running,
        inv_fwd_running})) else $error("status read wrong");
    a_mon_read: assert property (rd_go && haddr == 8'h20 |=> hrdata == {16'h0000,
        $past(mon_freq)}) else $error("frequency monitor wrong");
    c_net_run: cover property (op_mode == 2'h2 && fwd_run_cmd);
    c_param: cover property (param_we && inv_running);
    c_fault: cover property (fault_error_reset_req);
endmodule // dcss_asserts

// [dcss_far_model.sv]
// Terminal block and inverter model on the far side of the selector
`timescale 1ns/100ps
module dcss_far_model #(
    parameter [15:0] MFREQ = 16'h1388,
    parameter [15:0] MSPEC = 16'h0ABC
) (
    input  wire        hclk,
    input  wire [13:0] pin_set,
    input  wire [6:0]  inv_set,
    output reg  [13:0] pins,
    output reg  [6:0]  inv_st,
    output wire [15:0] mon_freq,
    output wire [15:0] mon_curr,
    output wire [15:0] mon_volt,
    output wire [15:0] mon_special
);
    always @(posedge hclk) begin
        pins   <= pin_set;
        inv_st <= inv_set;
    end
    // Unsigned binary: 50.00 Hz, 12.34 A, 350.0 V
    assign mon_freq    = MFREQ;
    assign mon_curr    = 16'h04D2;
    assign mon_volt    = 16'h0DAC;
    assign mon_special = MSPEC;
endmodule // dcss_far_model

// [tb_drive_command_source_select.sv]
// Self-checking bench for the command source selector
`timescale 1ns/100ps
module tb_drive_command_source_select;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [13:0] pin_set = 14'h0000;
    logic [6:0]  inv_set = 7'h00;
    wire  [13:0] pins;
    wire  [6:0]  st;
    wire  [15:0] mon_freq, mon_curr, mon_volt, mon_special, set_freq, param_data;
    wire  [31:0] hrdata;
    wire  [1:0]  op_mode;
    wire  [9:0]  param_num;
    wire  [7:0]  special_mon_sel;
    wire hreadyout, fwd_run_cmd, rev_run_cmd, speed_sel_low, speed_sel_mid, second_func_sel;
    wire current_input_sel, start_self_hold, output_shutoff, thermal_relay_in, pu_ext_switch;
    wire flux_vf_switch, inv_reset_out, fault_error_reset_req, freq_ram_we, freq_nv_we;
    wire remote_setting_active, param_we, speed_sel_high, speed_sel_ext15;
    int fails = 0;
    int comparisons = 0;
    int n_flt = 0, n_rst = 0, n_ram = 0, n_nv = 0, n_par = 0;
    logic [10:0] exp_drv [4] = '{11'h54F, 11'h316, 11'h4EF, 11'h2B6};

    always #12.5 hclk = ~hclk;

    dcss_far_model far (.hclk, .pin_set, .inv_set, .pins, .inv_st(st), .mon_freq, .mon_curr,
        .mon_volt, .mon_special);

    dcss_top #(.REFRESH_MAX_CYC(200)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata,
        .term_fwd(pins[0]), .term_rev(pins[1]), .term_low(pins[2]), .term_mid(pins[3]),
        .term_high(pins[4]), .term_ext15(pins[5]), .term_second(pins[6]),
        .term_curin(pins[7]), .term_selfhold(pins[8]), .term_shutoff(pins[9]),
        .term_thermal(pins[10]), .term_pu_ext(pins[11]), .term_flux(pins[12]),
        .hw_reset_in(pins[13]), .inv_fwd_running(st[0]), .inv_rev_running(st[1]),
        .inv_running(st[2]), .up_to_freq_flag(st[3]), .overload_flag(st[4]),
        .freq_detect_flag(st[5]), .inv_alarm(st[6]), .mon_freq, .mon_curr, .mon_volt,
        .mon_special, .fwd_run_cmd, .rev_run_cmd, .speed_sel_low, .speed_sel_mid,
        .speed_sel_high, .speed_sel_ext15, .remote_setting_active, .second_func_sel,
        .current_input_sel, .start_self_hold, .output_shutoff, .thermal_relay_in,
        .pu_ext_switch, .flux_vf_switch, .inv_reset_out, .fault_error_reset_req,
        .freq_ram_we, .freq_nv_we, .set_freq, .param_we, .param_num, .param_data,
        .special_mon_sel, .op_mode);

    always @(negedge hclk) begin
        n_flt += (fault_error_reset_req === 1'b1);
        n_rst += (inv_reset_out === 1'b1);
        n_ram += (freq_ram_we === 1'b1);
        n_nv  += (freq_nv_we === 1'b1);
        n_par += (param_we === 1'b1);
    end

    task automatic complete_run;
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_rdy;
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fails++;
            complete_run();
        end
    endtask

    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        ahb(a, 1'b1, d, t);
        repeat (8) @(posedge hclk);
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] m, exp);
        logic [31:0] t;
        ahb(a, 1'b0, 32'h0000_0000, t);
        chk(what, t & m, exp);
    endtask

    initial begin
        int b;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("op_mode", op_mode, 32'h0000_0001);
        rchk("cfg", 8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rchk("unmapped", 8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        pin_set <= 14'h0D0A;
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_07F5);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, c);
            chk("drive", {fwd_run_cmd, rev_run_cmd, speed_sel_low, speed_sel_mid,
                second_func_sel, current_input_sel, start_self_hold, output_shutoff,
                thermal_relay_in, pu_ext_switch, flux_vf_switch}, exp_drv[c]); // 11
        end
        wr(8'h00, 32'h0000_0070);
        chk("shutoff", output_shutoff, 32'h0000_0000);
        wr(8'h00, 32'h0000_0004);
        chk("remote", {remote_setting_active, speed_sel_low, speed_sel_high,
            speed_sel_ext15}, 32'h0000_000E);
        wr(8'h00, 32'h0000_0000);
        wr(8'h08, 32'h0000_0003);
        chk("both dirs", {fwd_run_cmd, rev_run_cmd}, 32'h0000_0000);
        wr(8'h04, 32'h0000_0001);
        chk("ext run", {fwd_run_cmd, rev_run_cmd}, 32'h0000_0001);
        wr(8'h04, 32'h0000_0000);
        chk("pu run", {fwd_run_cmd, rev_run_cmd}, 32'h0000_0000);
        pin_set <= 14'h2D0A;
        repeat (10) @(posedge hclk);
        chk("hw reset", inv_reset_out, 32'h0000_0001);
        pin_set <= 14'h0D0A;
        b = n_flt;
        wr(8'h0C, 32'h0000_0002);
        chk("fault reset", n_flt - b, 32'h0000_0001);
        inv_set <= 7'h55;
        rchk("status", 8'h1C, 32'h0000_007F, 32'h0000_0055);
        rchk("mon freq", 8'h20, 32'hFFFF_FFFF, 32'h0000_1388);
        rchk("mon curr", 8'h24, 32'hFFFF_FFFF, 32'h0000_04D2);
        rchk("mon volt", 8'h28, 32'hFFFF_FFFF, 32'h0000_0DAC);
        rchk("special off", 8'h2C, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h18, 32'h0000_00F3);
        chk("monitor select", special_mon_sel, 32'h0000_00F3);
        rchk("special", 8'h2C, 32'hFFFF_FFFF, 32'h0000_0ABC);
        wr(8'h04, 32'h0000_0002);
        wr(8'h10, 32'h0000_1388);
        b = n_ram;
        wr(8'h0C, 32'h0000_0004);
        chk("ram write", {16'(n_ram - b), set_freq}, 32'h0001_1388);
        b = n_nv;
        wr(8'h0C, 32'h0000_0008);
        chk("nv write", n_nv - b, 32'h0000_0001);
        wr(8'h04, 32'h0000_0001);
        b = n_ram;
        wr(8'h0C, 32'h0000_0004);
        chk("ext freq write", n_ram - b, 32'h0000_0000);
        wr(8'h04, 32'h0000_0002);
        inv_set <= 7'h04;
        wr(8'h14, 32'h00AA_0007);
        b = n_par;
        wr(8'h0C, 32'h0000_0010);
        chk("run param write", n_par - b, 32'h0000_0000);
        rchk("write error", 8'h1C, 32'h0000_0200, 32'h0000_0200);
        wr(8'h14, 32'h00AA_0004);
        wr(8'h0C, 32'h0000_0010);
        chk("exempt param write", {param_data, 6'(n_par - b), param_num}, 32'h00AA_0404);
        repeat (220) @(posedge hclk);
        rchk("comm error", 8'h1C, 32'h0000_0100, 32'h0000_0100);
        b = n_rst;
        wr(8'h0C, 32'h0000_0001);
        chk("net reset refused", n_rst - b, 32'h0000_0000);
        rchk("reset rejected", 8'h1C, 32'h0000_0400, 32'h0000_0400);
        wr(8'h08, 32'h0000_0000);
        rchk("comm ok", 8'h1C, 32'h0000_0100, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0001);
        chk("net reset", {30'(n_rst - b), op_mode}, 32'h0000_0005);
        wr(8'h00, 32'h0000_0100);
        wr(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0001);
        chk("link start", {30'(n_rst - b), op_mode}, 32'h0000_000A);
        complete_run();
    end
endmodule // tb_drive_command_source_select

bind dcss_top dcss_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .term_thermal, .hw_reset_in, .inv_fwd_running,
    .inv_rev_running, .inv_running, .up_to_freq_flag, .overload_flag, .freq_detect_flag,
    .inv_alarm, .mon_freq, .fwd_run_cmd, .rev_run_cmd, .thermal_relay_in, .inv_reset_out,
    .fault_error_reset_req, .freq_ram_we, .freq_nv_we, .param_we, .param_num, .op_mode);
